/* hbe_defs.vh */
// constants for the host bridge error status block
`ifndef HBE_DEFS_VH
`define HBE_DEFS_VH
`define HBE_CMD_OFFSET      8'h90
`define HBE_STS_OFFSET_LO   8'h91
`define HBE_STS_OFFSET_HI   8'h92
`define HBE_CMD_RESET       8'h80
`define HBE_STS_RESET       16'h0000
`define HBE_BIT_RD_THROT    12
`define HBE_BIT_WR_THROT    11
`define HBE_BIT_OUTSIDE     10
`define HBE_BIT_BAD_READ    9
`define HBE_BIT_BAD_XLAT    8
`define HBE_MB_ROW_HI       7
`define HBE_MB_ROW_LO       5
`define HBE_BIT_MB_FLAG     4
`define HBE_SB_ROW_HI       3
`define HBE_SB_ROW_LO       1
`define HBE_BIT_SB_FLAG     0
`define HBE_EN_OUTSIDE      7
`define HBE_EN_BAD_READ     6
`define HBE_EN_BAD_XLAT     5
`define HBE_EN_THROT        3
`define HBE_EN_LEVEL_MODE   2
`define HBE_EN_MULTI_BIT    1
`define HBE_EN_SINGLE_BIT   0
`endif

/* hbe_row_latch.v */
// first-error row capture with lock while its flag is set
`timescale 1ns/1ps
module hbe_row_latch (
   sys_clk,
   reset,
   err,
   row,
   flag_q,
   row_q
);
   input        sys_clk;
   input        reset;
   input        err;
   input  [2:0] row;
   input        flag_q;
   output [2:0] row_q;
   reg    [2:0] row_q;

   // only loads while the flag is clear, so first error wins
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         row_q <= 3'h0;
      end else if (err && !flag_q) begin
         row_q <= row;
      end
   end
endmodule // hbe_row_latch

/* hbe_error_status.v */
// error status and system error reporting for the host bridge
// Contract
// - flag rising edge raises enabled system error
// - bit 12 read throttle, write-one clear
// - bit 11 write throttle, write-one clear
// - bit 10 outside aperture access, w1c
// - bit 9 invalid graphics read, w1c
// - bit 8 invalid translation entry, w1c
// - bits 7:5 hold multi-bit error row
// - multi-bit row loads once, locked until clear
// - bit 4 multi-bit flag, clear unlocks row
// - multi-bit reported only with enable bit 1
// - bits 3:1 hold single-bit error row
// - single-bit row loads once, locked until clear
// - bit 0 single-bit flag, data corrected
// - single-bit reported only with enable bit 0
// - enables 7,6,5,3 gate reporting of their flags
// - mode bit selects pulse or level
// - output also needs command register enable
`timescale 1ns/1ps
`include "hbe_defs.vh"
module hbe_error_status (
   sys_clk,
   reset,
   cfg_addr,
   cfg_wr,
   cfg_wdata,
   cfg_rdata,
   serr_enable,
   rd_throttle,
   wr_throttle,
   outside_access,
   bad_read,
   bad_xlat,
   multi_bit_err,
   multi_bit_row,
   single_bit_err,
   single_bit_row,
   serr_out_n,
   serr_oe_n
);
   input        sys_clk;
   input        reset;
   input  [7:0] cfg_addr;
   input        cfg_wr;
   input  [7:0] cfg_wdata;
   output [7:0] cfg_rdata;
   input        serr_enable;
   input        rd_throttle;
   input        wr_throttle;
   input        outside_access;
   input        bad_read;
   input        bad_xlat;
   input        multi_bit_err;
   input  [2:0] multi_bit_row;
   input        single_bit_err;
   input  [2:0] single_bit_row;
   output       serr_out_n;
   output       serr_oe_n;

   reg    [7:0] cfg_rdata;
   reg          serr_out_n;
   reg          serr_oe_n;
   reg    [7:0] error_report_enable_q;
   reg    [7:0] error_report_enable_d;
   reg    [7:0] flags_q;
   reg    [7:0] flags_d;
   reg          serr_level_q;
   reg          serr_level_d;
   reg          serr_drive_d;
   reg    [7:0] rdata_d;
   wire         cmd_wr;
   wire         sts_lo_wr;
   wire         sts_hi_wr;
   wire   [7:0] set_v;
   wire   [7:0] clr_v;
   wire   [7:0] rise_v;
   wire   [2:0] mb_row_q;
   wire   [2:0] sb_row_q;
   wire  [15:0] error_status;
   wire         level_mode;
   wire         event_hit;
   wire         fire;

   // internal flag slots; slot 0 spare so edge detect stays uniform
   localparam FL_SB   = 1;
   localparam FL_MB   = 2;
   localparam FL_XLAT = 3;
   localparam FL_BAD  = 4;
   localparam FL_OUT  = 5;
   localparam FL_WR   = 6;
   localparam FL_RD   = 7;

   // byte wide config writes, one strobe per addressed byte
   assign cmd_wr    = cfg_wr && (cfg_addr == `HBE_CMD_OFFSET);
   assign sts_lo_wr = cfg_wr && (cfg_addr == `HBE_STS_OFFSET_LO);
   assign sts_hi_wr = cfg_wr && (cfg_addr == `HBE_STS_OFFSET_HI);

   // set side: one event input per flag
   assign set_v[FL_RD]   = rd_throttle;
   assign set_v[FL_WR]   = wr_throttle;
   assign set_v[FL_OUT]  = outside_access;
   assign set_v[FL_BAD]  = bad_read;
   assign set_v[FL_XLAT] = bad_xlat;
   assign set_v[FL_MB]   = multi_bit_err;
   assign set_v[FL_SB]   = single_bit_err;
   assign set_v[0]       = 1'b0;

   // clear side: write one to the flag's own bit position
   assign clr_v[FL_RD]   = sts_hi_wr & cfg_wdata[`HBE_BIT_RD_THROT - 8];
   assign clr_v[FL_WR]   = sts_hi_wr & cfg_wdata[`HBE_BIT_WR_THROT - 8];
   assign clr_v[FL_OUT]  = sts_hi_wr & cfg_wdata[`HBE_BIT_OUTSIDE - 8];
   assign clr_v[FL_BAD]  = sts_hi_wr & cfg_wdata[`HBE_BIT_BAD_READ - 8];
   assign clr_v[FL_XLAT] = sts_hi_wr & cfg_wdata[`HBE_BIT_BAD_XLAT - 8];
   assign clr_v[FL_MB]   = sts_lo_wr & cfg_wdata[`HBE_BIT_MB_FLAG];
   assign clr_v[FL_SB]   = sts_lo_wr & cfg_wdata[`HBE_BIT_SB_FLAG];
   assign clr_v[0]       = 1'b0;

   // set applied last so a clear in the same cycle never loses an event
   always @* begin
      flags_d = (flags_q & ~clr_v) | set_v;
   end
   assign rise_v = flags_d & ~flags_q;

   hbe_row_latch u_mb (
      .sys_clk (sys_clk),
      .reset   (reset),
      .err     (multi_bit_err),
      .row     (multi_bit_row),
      .flag_q  (flags_q[FL_MB]),
      .row_q   (mb_row_q)
   );
   hbe_row_latch u_sb (
      .sys_clk (sys_clk),
      .reset   (reset),
      .err     (single_bit_err),
      .row     (single_bit_row),
      .flag_q  (flags_q[FL_SB]),
      .row_q   (sb_row_q)
   );

   assign error_status[15:13] = 3'h0;
   assign error_status[`HBE_BIT_RD_THROT] = flags_q[FL_RD];
   assign error_status[`HBE_BIT_WR_THROT] = flags_q[FL_WR];
   assign error_status[`HBE_BIT_OUTSIDE]  = flags_q[FL_OUT];
   assign error_status[`HBE_BIT_BAD_READ] = flags_q[FL_BAD];
   assign error_status[`HBE_BIT_BAD_XLAT] = flags_q[FL_XLAT];
   assign error_status[`HBE_MB_ROW_HI:`HBE_MB_ROW_LO] = mb_row_q;
   assign error_status[`HBE_BIT_MB_FLAG]  = flags_q[FL_MB];
   assign error_status[`HBE_SB_ROW_HI:`HBE_SB_ROW_LO] = sb_row_q;
   assign error_status[`HBE_BIT_SB_FLAG]  = flags_q[FL_SB];

   assign level_mode = error_report_enable_q[`HBE_EN_LEVEL_MODE];
   assign event_hit =
      (rise_v[FL_RD] | rise_v[FL_WR]) & error_report_enable_q[`HBE_EN_THROT] |
      rise_v[FL_OUT] & error_report_enable_q[`HBE_EN_OUTSIDE] |
      rise_v[FL_BAD] & error_report_enable_q[`HBE_EN_BAD_READ] |
      rise_v[FL_XLAT] & error_report_enable_q[`HBE_EN_BAD_XLAT] |
      rise_v[FL_MB] & error_report_enable_q[`HBE_EN_MULTI_BIT] |
      rise_v[FL_SB] & error_report_enable_q[`HBE_EN_SINGLE_BIT];
   assign fire = event_hit & serr_enable;

   always @* begin
      error_report_enable_d = error_report_enable_q;
      if (cmd_wr) begin
         error_report_enable_d = cfg_wdata;
      end
   end

   // level mode holds until its mode bit or the system error enable drops
   always @* begin
      serr_level_d = serr_level_q;
      if (!level_mode || !serr_enable) begin
         serr_level_d = 1'b0;
      end else if (fire) begin
         serr_level_d = 1'b1;
      end
   end

   // gated by the live enables so release is not a cycle late
   always @* begin
      serr_drive_d = fire | (serr_level_q & level_mode & serr_enable);
   end

   // unmapped addresses read zero
   always @* begin
      case (cfg_addr)
         `HBE_CMD_OFFSET: begin
            rdata_d = error_report_enable_q;
         end
         `HBE_STS_OFFSET_LO: begin
            rdata_d = error_status[7:0];
         end
         `HBE_STS_OFFSET_HI: begin
            rdata_d = error_status[15:8];
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flags_q               <= 8'h00;
         error_report_enable_q <= `HBE_CMD_RESET;
      end else begin
         flags_q               <= flags_d;
         error_report_enable_q <= error_report_enable_d;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         serr_level_q <= 1'b0;
         serr_out_n   <= 1'b1;
         serr_oe_n    <= 1'b1;
      end else begin
         serr_level_q <= serr_level_d;
         // open drain: data parks low, the enable alone shapes the pulse
         serr_out_n   <= 1'b0;
         serr_oe_n    <= ~serr_drive_d;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cfg_rdata <= 8'h00;
      end else begin
         cfg_rdata <= rdata_d;
      end
   end
endmodule // hbe_error_status

/* hbe_props.sv */
// port-level checks for the error status block
`timescale 1ns/1ps
module hbe_props (
   input logic       sys_clk,
   input logic       reset,
   input logic [7:0] cfg_addr,
   input logic       cfg_wr,
   input logic [7:0] cfg_rdata,
   input logic       serr_enable,
   input logic       rd_throttle,
   input logic       wr_throttle,
   input logic       outside_access,
   input logic       bad_read,
   input logic       bad_xlat,
   input logic       multi_bit_err,
   input logic       single_bit_err,
   input logic       serr_oe_n
);
   wire any_ev = rd_throttle | wr_throttle | outside_access | bad_read |
                 bad_xlat | multi_bit_err | single_bit_err;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   serr_cause_a: assert property ($fell(serr_oe_n) |->
      $past(any_ev) && $past(serr_enable)) else $error("serr no cause");
   serr_gate_a: assert property (!$past(serr_enable) |-> serr_oe_n)
      else $error("serr while disabled");
   unmapped_zero_a: assert property (cfg_addr == 8'h93 |=>
      cfg_rdata == 8'h00) else $error("unmapped read not zero");
   rsvd_zero_a: assert property (cfg_addr == 8'h92 |=>
      cfg_rdata[7:5] == 3'h0) else $error("reserved bits set");
   sb_flag_a: assert property (single_bit_err ##1
      (cfg_addr == 8'h91 && !cfg_wr) |=> cfg_rdata[0])
      else $error("single flag missing");
   mb_flag_a: assert property (multi_bit_err ##1
      (cfg_addr == 8'h91 && !cfg_wr) |=> cfg_rdata[4])
      else $error("multi flag missing");
   rd_thr_a: assert property (rd_throttle ##1
      (cfg_addr == 8'h92 && !cfg_wr) |=> cfg_rdata[4])
      else $error("read throttle flag missing");
   wr_thr_a: assert property (wr_throttle ##1
      (cfg_addr == 8'h92 && !cfg_wr) |=> cfg_rdata[3])
      else $error("write throttle flag missing");
   cover property (single_bit_err ##1 !serr_oe_n);
   cover property (multi_bit_err ##1 !serr_oe_n [*3]);
   cover property (any_ev && cfg_wr);
endmodule // hbe_props

/* tb_top.sv */
// directed bench for the error status block
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 0, reset = 1, cfg_wr = 0, serr_enable = 1, so, oe;
   logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata;
   logic [6:0] ev = 0;
   logic [2:0] mr = 0, sr = 0;
   int fail_count = 0, total_checks = 0;
   hbe_error_status dut (.sys_clk(sys_clk), .reset(reset),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .serr_enable(serr_enable),
      .rd_throttle(ev[6]), .wr_throttle(ev[5]), .outside_access(ev[4]),
      .bad_read(ev[3]), .bad_xlat(ev[2]), .multi_bit_err(ev[1]),
      .multi_bit_row(mr), .single_bit_err(ev[0]), .single_bit_row(sr),
      .serr_out_n(so), .serr_oe_n(oe));
   initial forever #5 sys_clk = ~sys_clk;
   task chk(string n, logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(logic [7:0] a, d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1;
      @(negedge sys_clk);
      cfg_wr = 0;
   endtask
   // row fields keep their last captured row with their flag clear, hence the mask
   task rd(logic [7:0] a, e, m);
      cfg_addr = a;
      @(negedge sys_clk);
      chk("rdata", cfg_rdata & m, e);
   endtask
   task hit(logic [6:0] v, logic e);
      ev = v;
      @(negedge sys_clk);
      ev = 0;
      chk("serr", oe, e);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task t_reset;
      rd(8'h90, 8'h80, 8'hFF);
      rd(8'h91, 8'h00, 8'hFF);
      rd(8'h93, 8'h00, 8'hFF);
      chk("serr data", so, 0);
   endtask
   task t_single;
      wr(8'h90, 8'h01);
      sr = 3'h5;
      hit(7'h01, 0);
      rd(8'h91, 8'h0B, 8'hFF);
      chk("pulse", oe, 1);
      sr = 3'h2;
      hit(7'h01, 1);
      rd(8'h91, 8'h0B, 8'hFF);
      wr(8'h91, 8'h01);
      rd(8'h91, 8'h00, 8'h01);
      sr = 3'h3;
      hit(7'h01, 0);
      rd(8'h91, 8'h07, 8'hFF);
      sr = 3'h6;
      ev = 7'h01;
      wr(8'h91, 8'h01);
      ev = 0;
      rd(8'h91, 8'h07, 8'hFF);
   endtask
   task t_multi;
      wr(8'h90, 8'h06);
      mr = 3'h6;
      hit(7'h02, 0);
      rd(8'h91, 8'hD0, 8'hF0);
      mr = 3'h1;
      hit(7'h02, 0);
      rd(8'h91, 8'hD0, 8'hF0);
      chk("level", oe, 0);
      wr(8'h90, 8'h02);
      @(negedge sys_clk);
      chk("level off", oe, 1);
      wr(8'h91, 8'h10);
      rd(8'h91, 8'h00, 8'h10);
   endtask
   task t_flags;
      wr(8'h90, 8'hE8);
      for (int i = 2; i < 7; i++) begin
         hit(7'h01 << i, 0);
         rd(8'h92, 8'h01 << (i - 2), 8'hFF);
         wr(8'h92, 8'hFF);
      end
      serr_enable = 0;
      hit(7'h40, 1);
      serr_enable = 1;
      wr(8'h90, 8'h00);
      hit(7'h7F, 1);
      wr(8'h91, 8'hFF);
      @(negedge sys_clk);
      wr(8'h92, 8'hFF);
      rd(8'h92, 8'h00, 8'hFF);
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      chk("idle pins", {so, oe}, 8'h03);
      reset = 0;
      t_reset();
      t_single();
      t_multi();
      t_flags();
      end_of_test();
   end
   // under a hundred cycles of tests; far more means a hang
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
endmodule // tb_top
bind hbe_error_status hbe_props u_props (.*);
